// *** src/tdl_decoder.sv ***
// datalink message decoder: sync messages, alarm fields, far-end per-second counters
// How it works
// - sync messages decode only in extended superframe mode with receiver enabled.
// - each received sync message flag stays set until test restart.
// - any sync message pulses a time-stamped alarms report request.
// - separate flags: not-for-sync, SONET, stratum 1-4, unknown, user pattern.
// - alarm-seconds counts seconds with any alarm, 0 to 99999999.
// - past the maximum, overflow flag sets and low digits keep counting.
// - alarm field width is reported as 13 or 16 bits.
// - major alarm reported with shelf A-D, or with no shelf.
// - shelf-only alarm when a shelf alarms without a major alarm.
// - far-end loop requests flagged per shelf and for the protection line.
// - shelf on protection only after three consecutive frames say so.
// - minor and power/misc indications follow their conditions.
// - either test-abort code sets the test-abort indication.
// - conditions that end are kept as history apart from current ones.
// - far-end violation seconds count reports with the violation bit.
// - far-end slip seconds count reports with the slip bit.
// - six far-end CRC bin counters, one per bin bit.
// - CRC total adds bin minimums; greater-than flag when bins 2-6 nonzero.
// - payload source classified from command/response and loop bits.
`default_nettype none
`include "tdl_cfg.svh"

module tdl_decoder #(
    parameter int CNT_W = 32
) (
    // clock, reset, enable
    input wire logic clk,
    input wire logic reset,
    input wire logic ce,
    // register port
    input wire logic [3:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // test timing
    input wire logic second_tick,
    input wire logic test_restart,
    // sync message codewords
    input wire logic bpm_valid,
    input wire logic [7:0] bpm_code,
    // alarm and maintenance frame
    input wire logic frame_valid,
    input wire logic alarm_field_wide,
    input wire logic major_alarm,
    input wire logic minor_alarm,
    input wire logic power_misc_alarm,
    input wire logic [3:0] shelf_alarm,
    input wire logic [3:0] loop_req_shelf,
    input wire logic loop_req_prot,
    input wire logic [3:0] prot_switch,
    input wire logic [2:0] maint_code,
    // performance report
    input wire logic prm_valid,
    input wire logic line_violation_event_bit,
    input wire logic slip_event_bit,
    input wire logic [5:0] crc_bin_bits,
    input wire logic prm_cr,
    input wire logic payload_loop_bit,
    // report request
    output logic alarm_report_req
);

    // ****************************************
    // state
    // ****************************************
    typedef struct packed {
        logic [15:0] ctrl;
        logic [7:0] bit_pattern_message;
        logic report_req;
        logic [`TDL_IND_W-1:0] cur;
        logic [`TDL_IND_W-1:0] hist;
        logic [3:0][1:0] prot_cnt;
        logic alarm_field_width;
        logic [`TDL_ALM_SEC_W-1:0] alarm_seconds_count;
        logic alm_ovf;
        logic armed;
        logic sec_alarm;
        logic sec_lv;
        logic sec_sl;
        logic [5:0] sec_bins;
        logic [CNT_W-1:0] far_violation_seconds;
        logic [CNT_W-1:0] far_slip_seconds;
        logic [5:0][CNT_W-1:0] far_crc_bin;
        logic [CNT_W-1:0] crc_total;
        logic crc_gt;
        logic [1:0] payload_source_class;
        logic [31:0] rd_data;
    } tdl_state_t;

    tdl_state_t q;
    tdl_state_t next_q;

    // control word comes up with both receiver settings off
    localparam tdl_state_t Q_RESET = '{ctrl: `TDL_CTRL_RESET, default: '0};

    // minimum error count implied by each bin
    localparam logic [5:0][CNT_W-1:0] BIN_MIN = {
        CNT_W'(320), CNT_W'(101), CNT_W'(11), CNT_W'(6), CNT_W'(2), CNT_W'(1)
    };

    logic rx_enabled;
    logic [7:0] bpm_hit;
    logic [`TDL_IND_W-1:0] frame_ind;
    tdl_pkg::tdl_maint_t maint;

    assign rx_enabled = q.ctrl[`TDL_CTRL_ESF] & q.ctrl[`TDL_CTRL_BPM_EN];
    assign maint = tdl_pkg::tdl_maint_t'(maint_code);

    // ****************************************
    // codeword and frame decode
    // ****************************************
    always_comb begin
        bpm_hit[0] = bpm_code == `TDL_BPM_NOT_SYNC;
        bpm_hit[1] = bpm_code == `TDL_BPM_SONET;
        bpm_hit[2] = bpm_code == `TDL_BPM_STRATUM1;
        bpm_hit[3] = bpm_code == `TDL_BPM_STRATUM2;
        bpm_hit[4] = bpm_code == `TDL_BPM_STRATUM3;
        bpm_hit[5] = bpm_code == `TDL_BPM_STRATUM4;
        bpm_hit[6] = bpm_code == `TDL_BPM_UNKNOWN;
        bpm_hit[7] = bpm_code == q.ctrl[`TDL_CTRL_USER_LSB+:8];
    end

    always_comb begin
        frame_ind = '0;
        for (int i = 0; i < 4; i++) begin
            frame_ind[`TDL_IND_MAJ_SHELF+i] = major_alarm & shelf_alarm[i];
            frame_ind[`TDL_IND_SHELF_ONLY+i] = ~major_alarm & shelf_alarm[i];
            frame_ind[`TDL_IND_LOOP_SHELF+i] = loop_req_shelf[i];
        end
        frame_ind[`TDL_IND_MAJ_NOSHELF] = major_alarm & ~|shelf_alarm;
        frame_ind[`TDL_IND_LOOP_PROT] = loop_req_prot;
        frame_ind[`TDL_IND_MINOR] = minor_alarm;
        frame_ind[`TDL_IND_PWR] = power_misc_alarm;
        frame_ind[`TDL_IND_HOOK] = maint == tdl_pkg::maint_on_hook ||
            maint == tdl_pkg::maint_line_seize_code;
        frame_ind[`TDL_IND_PROCEED] = maint == tdl_pkg::maint_go_ahead_code_fwd ||
            maint == tdl_pkg::maint_go_ahead_code_rev;
        frame_ind[`TDL_IND_ABORT] = maint == tdl_pkg::maint_test_abort_code_fwd ||
            maint == tdl_pkg::maint_test_abort_code_rev;
    end

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        logic [`TDL_IND_W-1:0] new_ind;
        new_ind = '0;
        next_q = q;
        next_q.report_req = 1'b0;
        next_q.rd_data = 32'h0000_0000;
        // restart first, so that an event in the same cycle still lands
        if (test_restart) begin
            next_q.bit_pattern_message = 8'h00;
            next_q.cur = '0;
            next_q.hist = '0;
            next_q.prot_cnt = '0;
            next_q.alarm_seconds_count = '0;
            next_q.alm_ovf = 1'b0;
            next_q.armed = 1'b0;
            next_q.sec_alarm = 1'b0;
            next_q.sec_lv = 1'b0;
            next_q.sec_sl = 1'b0;
            next_q.sec_bins = 6'h00;
            next_q.far_violation_seconds = '0;
            next_q.far_slip_seconds = '0;
            next_q.far_crc_bin = '0;
            next_q.crc_total = '0;
            next_q.crc_gt = 1'b0;
        end
        // user pattern sits in the upper byte of the control word
        if (reg_wr && reg_addr == `TDL_REG_CTRL) begin
            next_q.ctrl = reg_wdata[15:0];
        end
        // second boundary: consume the events gathered during the second
        if (second_tick && !test_restart) begin
            if (q.armed) begin
                if (q.sec_alarm) begin
                    if (q.alarm_seconds_count == `TDL_ALM_SEC_MAX) begin
                        next_q.alarm_seconds_count = '0;
                        next_q.alm_ovf = 1'b1;
                    end else begin
                        next_q.alarm_seconds_count = q.alarm_seconds_count + 1'b1;
                    end
                end
                if (q.sec_lv) begin
                    next_q.far_violation_seconds = q.far_violation_seconds + 1'b1;
                end
                if (q.sec_sl) begin
                    next_q.far_slip_seconds = q.far_slip_seconds + 1'b1;
                end
                for (int b = 0; b < 6; b++) begin
                    if (q.sec_bins[b]) begin
                        next_q.far_crc_bin[b] = q.far_crc_bin[b] + 1'b1;
                        next_q.crc_total = next_q.crc_total + BIN_MIN[b];
                    end
                end
            end
            next_q.armed = 1'b1;
            next_q.sec_alarm = 1'b0;
            next_q.sec_lv = 1'b0;
            next_q.sec_sl = 1'b0;
            next_q.sec_bins = 6'h00;
        end
        next_q.crc_gt = next_q.far_crc_bin[1] != '0 || next_q.far_crc_bin[2] != '0 ||
            next_q.far_crc_bin[3] != '0 || next_q.far_crc_bin[4] != '0 ||
            next_q.far_crc_bin[5] != '0;
        // sync messages
        if (bpm_valid && rx_enabled) begin
            next_q.bit_pattern_message = next_q.bit_pattern_message | bpm_hit;
            next_q.report_req = 1'b1;
        end
        // alarm and maintenance frame
        if (frame_valid) begin
            new_ind = frame_ind;
            for (int i = 0; i < 4; i++) begin
                if (!prot_switch[i]) begin
                    next_q.prot_cnt[i] = 2'd0;
                end else if (next_q.prot_cnt[i] != `TDL_PROT_FRAMES) begin
                    // counts from the restarted value when both land together
                    next_q.prot_cnt[i] = next_q.prot_cnt[i] + 2'd1;
                end
                new_ind[`TDL_IND_ON_PROT+i] = next_q.prot_cnt[i] == `TDL_PROT_FRAMES;
            end
            next_q.hist = next_q.hist | (next_q.cur & ~new_ind);
            next_q.cur = new_ind;
            next_q.alarm_field_width = alarm_field_wide;
            if (major_alarm || minor_alarm || power_misc_alarm || |shelf_alarm) begin
                next_q.sec_alarm = 1'b1;
            end
        end
        // performance report
        if (prm_valid) begin
            next_q.sec_lv = next_q.sec_lv | line_violation_event_bit;
            next_q.sec_sl = next_q.sec_sl | slip_event_bit;
            next_q.sec_bins = next_q.sec_bins | crc_bin_bits;
            next_q.payload_source_class = {payload_loop_bit, prm_cr};
        end
        // register reads
        if (reg_rd) begin
            unique case (reg_addr)
                `TDL_REG_CTRL: next_q.rd_data = {16'h0000, q.ctrl};
                `TDL_REG_BPM: next_q.rd_data = {24'h000000, q.bit_pattern_message};
                `TDL_REG_CUR: next_q.rd_data = 32'(q.cur);
                `TDL_REG_HIST: next_q.rd_data = 32'(q.hist);
                `TDL_REG_ALM_SEC: begin
                    next_q.rd_data = 32'(q.alarm_seconds_count);
                    next_q.rd_data[`TDL_ALM_SEC_OVF] = q.alm_ovf;
                end
                `TDL_REG_MISC: begin
                    next_q.rd_data[4:0] = q.alarm_field_width ? `TDL_FIELD_WIDE :
                        `TDL_FIELD_NARROW;
                    next_q.rd_data[`TDL_MISC_SRC_LSB+:2] = q.payload_source_class;
                    next_q.rd_data[`TDL_MISC_CRC_GT] = q.crc_gt;
                end
                `TDL_REG_VIOL: next_q.rd_data = 32'(q.far_violation_seconds);
                `TDL_REG_SLIP: next_q.rd_data = 32'(q.far_slip_seconds);
                `TDL_REG_CRC_TOTAL: next_q.rd_data = 32'(q.crc_total);
                default: begin
                    if (reg_addr >= `TDL_REG_BIN0 && reg_addr <= `TDL_REG_BIN5) begin
                        next_q.rd_data = 32'(q.far_crc_bin[3'(reg_addr - `TDL_REG_BIN0)]);
                    end
                end
            endcase
        end
    end

    // ****************************************
    // registers
    // ****************************************
    // a low enable freezes every field, read data included
    // reset wins over the enable so a frozen block still comes up clean
    always_ff @(posedge clk) begin
        if (reset) begin
            q <= Q_RESET;
        end else if (ce) begin
            q <= next_q;
        end
    end

    // outputs come straight from the state flops
    assign reg_rdata = q.rd_data;
    assign alarm_report_req = q.report_req;

    // ****************************************
    // checks
    // ****************************************
    // one clock domain; checks stand down while reset is high
    default clocking chk_clk @(posedge clk);
    endclocking
    default disable iff (reset);

    // a frame taken in a cycle without restart
    sequence s_frame;
        ce && frame_valid && !test_restart;
    endsequence

    // a sync code taken while the receiver listens
    sequence s_code_taken;
        ce && bpm_valid && rx_enabled;
    endsequence

    // third switch frame in a row for shelf B
    sequence s_third_switch;
        s_frame ##0 (prot_switch[1] && q.prot_cnt[1] == 2'd2);
    endsequence

    // one request per accepted code
    chk_code_report: assert property (s_code_taken |=> alarm_report_req)
        else $error("sync code gave no report request");

    // receiver settings gate the request as well as the flags
    chk_code_gated: assert property (ce && !(bpm_valid && rx_enabled) |=>
        !alarm_report_req)
        else $error("report request without an accepted sync code");

    // flags only gain bits until restart
    chk_flags_held: assert property (ce && !test_restart |=>
        !(|(~q.bit_pattern_message & $past(q.bit_pattern_message))))
        else $error("sync message flag dropped without restart");

    chk_prot_third: assert property (s_third_switch |=> q.cur[`TDL_IND_ON_PROT+1])
        else $error("shelf B not on protection after three frames");

    // a break restarts the count, so fewer than two seen cannot show
    chk_prot_early: assert property (s_frame ##0 q.prot_cnt[1] < 2'd2 |=>
        !q.cur[`TDL_IND_ON_PROT+1])
        else $error("shelf B on protection too early");

    chk_major_shelf: assert property (s_frame ##0 major_alarm |=>
        q.cur[`TDL_IND_MAJ_SHELF+:4] == $past(shelf_alarm))
        else $error("major alarm shelf flags wrong");

    chk_shelf_only: assert property (s_frame ##0 !major_alarm |=>
        q.cur[`TDL_IND_SHELF_ONLY+:4] == $past(shelf_alarm))
        else $error("shelf-only alarm flags wrong");

    // either direction of the abort code
    chk_test_abort: assert property (s_frame ##0 maint_code inside {3'h5, 3'h6} |=>
        q.cur[`TDL_IND_ABORT])
        else $error("test-abort code not shown");

    chk_field_width: assert property (ce && frame_valid |=>
        q.alarm_field_width == $past(alarm_field_wide))
        else $error("alarm field width not taken from the frame");

    // the wrap at the maximum is out of reach of any run; counting is not
    chk_alarm_count: assert property (ce && second_tick && !test_restart && q.armed &&
        q.sec_alarm && q.alarm_seconds_count != `TDL_ALM_SEC_MAX |=>
        q.alarm_seconds_count == $past(q.alarm_seconds_count) + 1'b1)
        else $error("alarm second not counted");

    // any second in bins two to six marks the total as a minimum
    chk_crc_more: assert property (ce && second_tick && !test_restart && q.armed &&
        (|q.sec_bins[5:1]) |=> q.crc_gt)
        else $error("greater-than qualifier missing");

    // a restart also drops the partial second in flight
    chk_restart_clear: assert property (ce && test_restart |=>
        q.hist == '0 && q.alarm_seconds_count == '0 && q.crc_total == '0 && !q.armed)
        else $error("restart left history or counters set");

endmodule

`default_nettype wire

// *** pkg/tdl_cfg.svh ***
// constants of the datalink message decoder: offsets, field positions, counts
`ifndef TDL_CFG_SVH
`define TDL_CFG_SVH

// ****************************************
// register word indices
// ****************************************
`define TDL_REG_CTRL 4'h0
`define TDL_REG_BPM 4'h1
`define TDL_REG_CUR 4'h2
`define TDL_REG_HIST 4'h3
`define TDL_REG_ALM_SEC 4'h4
`define TDL_REG_MISC 4'h5
`define TDL_REG_VIOL 4'h6
`define TDL_REG_SLIP 4'h7
`define TDL_REG_BIN0 4'h8
`define TDL_REG_BIN5 4'hd
`define TDL_REG_CRC_TOTAL 4'he

// ****************************************
// control word fields and reset value
// ****************************************
`define TDL_CTRL_ESF 0
`define TDL_CTRL_BPM_EN 1
`define TDL_CTRL_USER_LSB 8
`define TDL_CTRL_RESET 16'h0000

// ****************************************
// indication vector positions (current and history)
// ****************************************
`define TDL_IND_W 23
`define TDL_IND_MAJ_SHELF 0
`define TDL_IND_MAJ_NOSHELF 4
`define TDL_IND_SHELF_ONLY 5
`define TDL_IND_LOOP_SHELF 9
`define TDL_IND_LOOP_PROT 13
`define TDL_IND_ON_PROT 14
`define TDL_IND_MINOR 18
`define TDL_IND_PWR 19
`define TDL_IND_HOOK 20
`define TDL_IND_PROCEED 21
`define TDL_IND_ABORT 22

// ****************************************
// misc status word positions, and the alarm-seconds overflow bit
// ****************************************
`define TDL_MISC_SRC_LSB 8
`define TDL_MISC_CRC_GT 16
`define TDL_ALM_SEC_OVF 31

// ****************************************
// counts
// ****************************************
`define TDL_ALM_SEC_W 27
`define TDL_ALM_SEC_MAX 27'd99999999
`define TDL_PROT_FRAMES 2'd3
`define TDL_FIELD_NARROW 5'd13
`define TDL_FIELD_WIDE 5'd16

// ****************************************
// bit-patterned message codewords
// ****************************************
`define TDL_BPM_NOT_SYNC 8'h30
`define TDL_BPM_SONET 8'h22
`define TDL_BPM_STRATUM1 8'h04
`define TDL_BPM_STRATUM2 8'h28
`define TDL_BPM_STRATUM3 8'h2a
`define TDL_BPM_STRATUM4 8'h14
`define TDL_BPM_UNKNOWN 8'h08

`endif

// *** pkg/tdl_pkg.sv ***
// types of the datalink message decoder
`default_nettype none

package tdl_pkg;

    // maintenance field codes
    typedef enum logic [2:0] {
        maint_idle = 3'h0,
        maint_on_hook = 3'h1,
        maint_line_seize_code = 3'h2,
        maint_go_ahead_code_fwd = 3'h3,
        maint_go_ahead_code_rev = 3'h4,
        maint_test_abort_code_fwd = 3'h5,
        maint_test_abort_code_rev = 3'h6
    } tdl_maint_t;

    // payload source class, index is {loop bit, command/response bit}
    typedef enum logic [1:0] {
        src_customer_origin = 2'h0,
        src_carrier_origin = 2'h1,
        src_customer_looped = 2'h2,
        src_carrier_looped = 2'h3
    } tdl_src_t;

endpackage

`default_nettype wire

// *** test/tdl_far_end.sv ***
// far-end line equipment model: sync codes, alarm frames, performance reports
`default_nettype none

module tdl_far_end (
    // clock
    input wire logic clk,
    // message streams
    output logic bpm_valid,
    output logic [7:0] bpm_code,
    output logic frame_valid,
    output logic [19:0] frame,
    output logic prm_valid,
    output logic [9:0] performance_report_message
);
    timeunit 1ns;
    timeprecision 1ns;

    initial begin
        bpm_valid = 1'b0;
        frame_valid = 1'b0;
        prm_valid = 1'b0;
        bpm_code = 8'h00;
        frame = 20'h00000;
        performance_report_message = 10'h000;
    end

    // k: 0 sync code, 1 frame, 2 report; gap idles first to act slow
    // released fields carry inverted data so a stale value cannot pass
    task automatic send(input int k, input logic [19:0] d, input int gap);
        repeat (gap) @(posedge clk);
        @(posedge clk);
        bpm_valid <= (k == 0);
        frame_valid <= (k == 1);
        prm_valid <= (k == 2);
        bpm_code <= d[7:0];
        frame <= d;
        performance_report_message <= d[9:0];
        @(posedge clk);
        bpm_valid <= 1'b0;
        frame_valid <= 1'b0;
        prm_valid <= 1'b0;
        bpm_code <= ~d[7:0];
        frame <= ~d;
        performance_report_message <= ~d[9:0];
    endtask
endmodule

`default_nettype wire

// *** test/tb_top.sv ***
// self-checking bench of the datalink message decoder
`default_nettype none
`include "tdl_cfg.svh"

module tb_top;
    timeunit 1ns;
    timeprecision 1ns;

    logic clk, reset, second_tick, test_restart, reg_wr, reg_rd, alarm_report_req, req_q;
    logic [3:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, rd_val;
    logic bpm_valid, frame_valid, prm_valid;
    logic [7:0] bpm_code;
    logic [19:0] frame;
    logic [9:0] performance_report_message;
    logic [22:0] hist_exp;
    int mismatches = 0;
    int cmp_count = 0;
    int req_rises = 0;

    // frame: wide,major,minor,pwr,shelf[4],loop[4],prot,switch[4],maint[3]
    localparam logic [42:0] ROWS [12] = '{
        {20'h41000, 23'h1 << `TDL_IND_MAJ_SHELF},
        {20'h40000, 23'h1 << `TDL_IND_MAJ_NOSHELF},
        {20'h02000, 23'h1 << (`TDL_IND_SHELF_ONLY + 1)},
        {20'h00480, (23'h1 << (`TDL_IND_LOOP_SHELF + 2)) | (23'h1 << `TDL_IND_LOOP_PROT)},
        {20'h20000, 23'h1 << `TDL_IND_MINOR},
        {20'h10000, 23'h1 << `TDL_IND_PWR},
        {20'h00001, 23'h1 << `TDL_IND_HOOK},
        {20'h00002, 23'h1 << `TDL_IND_HOOK},
        {20'h00003, 23'h1 << `TDL_IND_PROCEED},
        {20'h00004, 23'h1 << `TDL_IND_PROCEED},
        {20'h00005, 23'h1 << `TDL_IND_ABORT},
        {20'h00006, 23'h1 << `TDL_IND_ABORT}};
    localparam logic [7:0] CODES [8] = '{`TDL_BPM_NOT_SYNC, `TDL_BPM_SONET,
        `TDL_BPM_STRATUM1, `TDL_BPM_STRATUM2, `TDL_BPM_STRATUM3,
        `TDL_BPM_STRATUM4, `TDL_BPM_UNKNOWN, 8'h5a};
    // report: violation,slip,bins[6],cr,loop; expected source class
    localparam logic [11:0] PRMS [3] = '{{10'h206, 2'h1}, {10'h109, 2'h2}, {10'h083, 2'h3}};

    tdl_decoder DUT (
        .clk(clk), .reset(reset), .ce(1'b1),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .second_tick(second_tick), .test_restart(test_restart),
        .bpm_valid(bpm_valid), .bpm_code(bpm_code), .frame_valid(frame_valid),
        .alarm_field_wide(frame[19]), .major_alarm(frame[18]), .minor_alarm(frame[17]),
        .power_misc_alarm(frame[16]), .shelf_alarm(frame[15:12]),
        .loop_req_shelf(frame[11:8]), .loop_req_prot(frame[7]), .prot_switch(frame[6:3]),
        .maint_code(frame[2:0]), .prm_valid(prm_valid), .line_violation_event_bit(performance_report_message[9]),
        .slip_event_bit(performance_report_message[8]), .crc_bin_bits(performance_report_message[7:2]), .prm_cr(performance_report_message[1]),
        .payload_loop_bit(performance_report_message[0]), .alarm_report_req(alarm_report_req));

    tdl_far_end far (
        .clk(clk), .bpm_valid(bpm_valid), .bpm_code(bpm_code), .frame_valid(frame_valid),
        .frame(frame), .prm_valid(prm_valid), .performance_report_message(performance_report_message));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    always @(posedge clk) begin
        req_q <= alarm_report_req;
        if (alarm_report_req === 1'b1 && req_q !== 1'b1) req_rises <= req_rises + 1;
    end

    // ****************************************
    // tasks
    // ****************************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic rc(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
        repeat (2) @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rdata & m, e);
    endtask

    task automatic pulse(input bit rs);
        @(posedge clk);
        if (rs) test_restart <= 1'b1;
        else second_tick <= 1'b1;
        @(posedge clk);
        test_restart <= 1'b0;
        second_tick <= 1'b0;
    endtask

    task automatic test_done;
        $display("Comparisons %0d, mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // ****************************************
    // sequence
    // ****************************************
    initial begin
        {second_tick, test_restart, reg_wr, reg_rd} = 4'h0;
        reg_addr = 4'h0;
        reg_wdata = 32'h0;
        hist_exp = 23'h0;
        reset = 1'b1;
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        rc(`TDL_REG_CTRL, 32'hffffffff, 32'h0);
        rc(`TDL_REG_ALM_SEC, 32'hffffffff, 32'h0);
        for (int i = 0; i < 12; i++) begin
            far.send(1, ROWS[i][42:23], i % 2);
            rc(`TDL_REG_CUR, 32'h7fffff, {9'h0, ROWS[i][22:0]});
            if (i < 11) hist_exp |= ROWS[i][22:0];
        end
        rc(`TDL_REG_HIST, {9'h0, ~ROWS[11][22:0]}, {9'h0, hist_exp & ~ROWS[11][22:0]});
        rc(`TDL_REG_MISC, 32'h1f, 32'(`TDL_FIELD_NARROW));
        far.send(1, 20'h80000, 0);
        rc(`TDL_REG_MISC, 32'h1f, 32'(`TDL_FIELD_WIDE));
        // a break between switch frames restarts the count
        far.send(1, 20'h00008, 0);
        far.send(1, 20'h00008, 0);
        far.send(1, 20'h00000, 0);
        far.send(1, 20'h00008, 0);
        rc(`TDL_REG_CUR, 32'h1 << `TDL_IND_ON_PROT, 32'h0);
        repeat (3) far.send(1, 20'h00010, 0);
        rc(`TDL_REG_CUR, 32'h7fffff, 32'h1 << (`TDL_IND_ON_PROT + 1));
        // sync codes ignored while the receiver is off
        far.send(0, {12'h0, `TDL_BPM_NOT_SYNC}, 0);
        rc(`TDL_REG_BPM, 32'hff, 32'h0);
        // either setting alone still ignores codes
        for (int m = 1; m < 3; m++) begin
            wr(`TDL_REG_CTRL, 32'(m));
            far.send(0, {12'h0, `TDL_BPM_SONET}, 0);
            rc(`TDL_REG_BPM, 32'hff, 32'h0);
        end
        chk(32'(req_rises), 32'h0);
        wr(`TDL_REG_CTRL, 32'h00005a03);
        rc(`TDL_REG_CTRL, 32'hffff, 32'h00005a03);
        for (int i = 0; i < 8; i++) begin
            far.send(0, {12'h0, CODES[i]}, i % 3);
            rc(`TDL_REG_BPM, 32'hff, (32'h2 << i) - 32'h1);
            chk(32'(req_rises), 32'(i + 1));
        end
        // alarm seconds and far-end counters
        pulse(1'b1);
        pulse(1'b0);
        far.send(1, 20'h40000, 0);
        far.send(1, 20'h00000, 0);
        pulse(1'b0);
        pulse(1'b0);
        rc(`TDL_REG_ALM_SEC, 32'h87ffffff, 32'h1);
        for (int i = 0; i < 3; i++) begin
            far.send(2, {10'h0, PRMS[i][11:2]}, i);
            pulse(1'b0);
            rc(`TDL_REG_MISC, 32'h300, {22'h0, PRMS[i][1:0], 8'h0});
        end
        rc(`TDL_REG_VIOL, 32'hffffffff, 32'h1);
        rc(`TDL_REG_SLIP, 32'hffffffff, 32'h1);
        rc(`TDL_REG_BIN0, 32'hffffffff, 32'h1);
        rc(`TDL_REG_BIN0 + 4'h1, 32'hffffffff, 32'h1);
        rc(`TDL_REG_BIN0 + 4'h2, 32'hffffffff, 32'h0);
        rc(`TDL_REG_BIN5, 32'hffffffff, 32'h1);
        rc(`TDL_REG_CRC_TOTAL, 32'hffff, 32'd323);
        rc(`TDL_REG_MISC, 32'h1 << `TDL_MISC_CRC_GT, 32'h1 << `TDL_MISC_CRC_GT);
        // restart clears latched flags, history and counters
        pulse(1'b1);
        rc(`TDL_REG_BPM, 32'hff, 32'h0);
        rc(`TDL_REG_HIST, 32'h7fffff, 32'h0);
        rc(`TDL_REG_ALM_SEC, 32'hffffffff, 32'h0);
        rc(`TDL_REG_VIOL, 32'hffffffff, 32'h0);
        rc(`TDL_REG_CRC_TOTAL, 32'hffffffff, 32'h0);
        rc(4'hf, 32'hffffffff, 32'h0);
        // reset in mid-run returns the control word to its reset value
        @(posedge clk);
        reset <= 1'b1;
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        rc(`TDL_REG_CTRL, 32'hffffffff, 32'h0);
        test_done;
    end

    initial begin
        repeat (5000) @(posedge clk);
        mismatches++;
        test_done;
    end
endmodule

`default_nettype wire
